// >>> verif/dispatch_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module dispatch_monitor (
    input wire logic       mclk_i,
    input wire logic       rstn_i,
    input wire logic [1:0] app_type_i,
    input wire logic       tx_fitted_i,
    input wire logic       ctrl_bus_rx_primary_i,
    input wire logic       ctrl_bus_tx_out_o,
    input wire logic       rx_primary_o,
    input wire logic       reply_bit_i,
    input wire logic       reply_active_i,
    input wire logic       req_valid_i,
    input wire logic [2:0] req_router_i,
    input wire logic       req_ready_o,
    input wire logic       req_refused_o,
    input wire logic       leg_valid_i,
    input wire logic       leg_from_secondary_i,
    input wire logic [3:0] leg_bits_i,
    input wire logic       busy_o,
    input wire logic       done_o,
    input wire logic [3:0] scl_o,
    input wire logic [3:0] scl_oe_n_o,
    input wire logic [3:0] sda_o,
    input wire logic [3:0] sda_oe_n_o
);
    logic [1:0] sel;
    logic       allowed;
    logic       taken;
    // Routers reserved by the legacy applications are turned away
    assign allowed = !((app_type_i == 2'h1 && req_router_i[2]) || (app_type_i == 2'h2 && req_router_i == 3'h7));
    assign taken   = req_valid_i && req_ready_o;
    // Line of the last request taken; only that line may move in a router-only setup
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel <= 2'h0;
        end else if (taken) begin
            sel <= req_router_i[2:1];
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    a_take_busy: assert property (taken && allowed |=> busy_o)
        else $error("busy not raised after a taken request");
    a_refuse_pulse: assert property (taken && !allowed |=> req_refused_o && !busy_o)
        else $error("reserved router not refused");
    a_busy_blocks: assert property (busy_o |-> !req_ready_o)
        else $error("ready while a frame runs");
    a_done_idle: assert property (done_o |-> !busy_o ##1 !done_o)
        else $error("done not a single pulse ending the frame");
    a_line_select: assert property (busy_o && app_type_i == 2'h0 |-> ((sda_oe_n_o & scl_oe_n_o) | (4'h1 << sel)) == 4'hF)
        else $error("unselected line driven");
    a_matrix_drive: assert property (leg_valid_i && !leg_from_secondary_i && app_type_i == 2'h1 |=>
        {sda_o[3], scl_o[3], sda_o[2], scl_o[2]} == $past(leg_bits_i) && (scl_oe_n_o[3:2] | sda_oe_n_o[3:2]) == 2'h0)
        else $error("matrix outputs do not follow legacy bits");
    a_reply_follow: assert property (reply_active_i && tx_fitted_i |=> ctrl_bus_tx_out_o == $past(reply_bit_i))
        else $error("transmit pin does not follow reply");
    a_tx_quiet: assert property (!(reply_active_i && tx_fitted_i) |=> ctrl_bus_tx_out_o)
        else $error("transmit pin active without reply or transistor");
    a_rx_sync: assert property ($stable(ctrl_bus_rx_primary_i) [*3] |-> rx_primary_o == ctrl_bus_rx_primary_i)
        else $error("primary receive level not passed on");
    c_refused: cover property (req_refused_o);
    c_done: cover property (done_o);
    c_matrix: cover property (leg_valid_i && app_type_i == 2'h1);
endmodule : dispatch_monitor
`default_nettype wire

// >>> verif/router_partner.sv
`timescale 1ns/100ps
`default_nettype none
module router_partner (
    input  wire logic [3:0] scl_i,
    input  wire logic [3:0] sda_i,
    input  wire logic       nack_i,
    output logic [3:0]      pull_o,
    output logic [3:0]      tog_o,
    output logic [7:0]      byte_o [4]
);
    // One router pair per line; the pull-up brings the line high once released
    for (genvar g = 0; g < 4; g++) begin : g_line
        int         cnt = 9;
        logic [7:0] sh;
        initial pull_o[g] = 1'b0;
        initial tog_o[g] = 1'b0;
        // A start restarts the bit count
        always @(negedge sda_i[g]) if (scl_i[g]) cnt = 0;
        // Bits are taken on the rising clock, most significant first
        always @(posedge scl_i[g]) begin
            if (cnt < 8) begin
                sh = {sh[6:0], sda_i[g]};
                cnt++;
            end else if (cnt == 8) begin
                cnt = 0;
            end
        end
        // Acknowledge held low over the ninth clock unless told to refuse
        always @(negedge scl_i[g]) begin
            pull_o[g] <= (cnt == 8) && !nack_i;
            if (cnt == 8) begin
                byte_o[g] = sh;
                tog_o[g] = !tog_o[g];
            end
        end
    end
endmodule : router_partner
`default_nettype wire

// >>> verif/tb_channel_router_i2c_dispatch.sv
`timescale 1ns/100ps
`default_nettype none
module tb_channel_router_i2c_dispatch;
    logic [1:0] app;
    logic       clk, rst_n, fit, rxp, rxs, rbit, ract, rv, rsec, lv, lsec, llc, nk;
    logic       tx, rxpo, rxso, rdy, rref, lref, busy, done, nack;
    logic [2:0] rr;
    logic [7:0] d1, d2;
    logic [3:0] lbits, scl, scl_oe_n, sda, sda_oe_n, scl_w, sda_w, pull, tog;
    logic [7:0] rxb [4];
    logic [9:0] expq [$];
    int         fail_count, total_checks, cyc;
    // Open-drain wires: low when any party pulls low
    assign scl_w = scl | scl_oe_n;
    assign sda_w = (sda | sda_oe_n) & ~pull;
    channel_router_i2c_dispatch DUT (
        .mclk_i(clk), .rstn_i(rst_n), .app_type_i(app), .tx_fitted_i(fit),
        .ctrl_bus_rx_primary_i(rxp), .ctrl_bus_rx_secondary_i(rxs), .ctrl_bus_tx_out_o(tx),
        .rx_primary_o(rxpo), .rx_secondary_o(rxso), .reply_bit_i(rbit), .reply_active_i(ract),
        .req_valid_i(rv), .req_from_secondary_i(rsec), .req_router_i(rr), .req_data1_i(d1),
        .req_data2_i(d2), .req_ready_o(rdy), .req_refused_o(rref), .leg_valid_i(lv),
        .leg_from_secondary_i(lsec), .leg_level_change_i(llc), .leg_bits_i(lbits),
        .leg_refused_o(lref), .busy_o(busy), .done_o(done), .nack_o(nack), .scl_o(scl),
        .scl_oe_n_o(scl_oe_n), .sda_o(sda), .sda_oe_n_o(sda_oe_n), .sda_i(sda_w));
    router_partner u_partner (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nk), .pull_o(pull), .tog_o(tog), .byte_o(rxb));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic cmp(input string nm, input logic [9:0] e, input logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    // Inputs move a fixed 5 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask : tick
    task automatic finish_frame(input logic bad);
        int n = 0;
        while (done !== 1'b1 && n < 8000) begin
            tick(1);
            n++;
        end
        cmp("done", 10'h1, 10'(done));
        cmp("nack", 10'(bad), 10'(nack));
        tick(1);
    endtask : finish_frame
    task automatic req(input logic [2:0] r, input logic bad);
        cmp("ready", 10'h1, 10'(rdy));
        rr = r;
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        nk = bad;
        rsec = 1'($urandom);
        rv = 1'b1;
        tick(1);
        rv = 1'b0;
        cmp("busy", 10'h1, 10'(busy));
        expq.push_back({r[2:1], (r[0] ? 8'hCA : 8'hC8)});
        if (!bad) expq.push_back({r[2:1], d1});
        if (!bad) expq.push_back({r[2:1], d2});
        finish_frame(bad);
    endtask : req
    task automatic leg(input logic s, input logic c, input logic e);
        lbits = 4'($urandom);
        lsec = s;
        llc = c;
        lv = 1'b1;
        tick(1);
        lv = 1'b0;
        cmp("leg_refused", 10'(e), 10'(lref));
        if (app == 2'h1 && !e) cmp("matrix", 10'(lbits), 10'({sda[3], scl[3], sda[2], scl[2]}));
        if (app == 2'h2 && !e) begin
            expq.push_back({2'h3, 8'hCA});
            expq.push_back({2'h3, 4'h0, lbits});
            expq.push_back(10'h300);
            finish_frame(1'b0);
        end
        tick(1);
    endtask : leg
    // Every byte a router receives is matched against the oldest note
    initial begin
        logic [3:0] prev;
        prev = 4'h0;
        forever begin
            @(tog);
            for (int i = 0; i < 4; i++) begin
                if (tog[i] != prev[i]) cmp("byte", expq.size() > 0 ? expq.pop_front() : 10'h3FF, {2'(i), rxb[i]});
            end
            prev = tog;
        end
    end
    // Hang guard, well above nine frames of traffic
    always @(posedge clk) begin
        cyc++;
        if (cyc > 70000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h0BBE));
        {rst_n, fit, rxp, rxs, rbit, ract, rv, rsec, lv, lsec, llc, nk} = 12'h300;
        {app, rr, d1, d2, lbits} = 25'h0000000;
        tick(2);
        rst_n = 1'b1;
        cmp("tx", 10'h1, 10'(tx));
        for (int r = 0; r < 8; r++) req(3'(r), r == 6);
        // A reset in mid-frame must free every line at once
        rv = 1'b1;
        tick(1);
        rv = 1'b0;
        tick(100);
        rst_n = 1'b0;
        #1;
        cmp("idle", 10'h0FF, 10'({busy, scl_oe_n, sda_oe_n}));
        tick(1);
        rst_n = 1'b1;
        leg(1'b0, 1'b1, 1'b1);
        app = 2'h1;
        rr = 3'h5;
        rv = 1'b1;
        tick(1);
        rv = 1'b0;
        cmp("refused", 10'h1, 10'(rref));
        leg(1'b1, 1'b1, 1'b1);
        leg(1'b0, 1'b1, 1'b0);
        leg(1'b1, 1'b1, 1'b0);
        leg(1'b1, 1'b0, 1'b1);
        app = 2'h2;
        rr = 3'h7;
        rv = 1'b1;
        tick(1);
        rv = 1'b0;
        cmp("refused", 10'h1, 10'(rref));
        leg(1'b0, 1'b1, 1'b0);
        {rxp, rxs, fit, ract} = 4'h3;
        repeat (20) begin
            rbit = 1'($urandom);
            tick(1);
            cmp("tx", 10'(rbit), 10'(tx));
        end
        cmp("rx", 10'h0, 10'({rxpo, rxso}));
        fit = 1'b0;
        tick(2);
        cmp("tx", 10'h1, 10'(tx));
        cmp("pending", 10'h0, 10'(expq.size()));
        test_done();
    end
endmodule : tb_channel_router_i2c_dispatch
bind channel_router_i2c_dispatch dispatch_monitor u_mon (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .app_type_i(app_type_i), .tx_fitted_i(tx_fitted_i),
    .ctrl_bus_rx_primary_i(ctrl_bus_rx_primary_i), .ctrl_bus_tx_out_o(ctrl_bus_tx_out_o),
    .rx_primary_o(rx_primary_o), .reply_bit_i(reply_bit_i), .reply_active_i(reply_active_i),
    .req_valid_i(req_valid_i), .req_router_i(req_router_i), .req_ready_o(req_ready_o),
    .req_refused_o(req_refused_o), .leg_valid_i(leg_valid_i), .leg_from_secondary_i(leg_from_secondary_i),
    .leg_bits_i(leg_bits_i), .busy_o(busy_o), .done_o(done_o), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
`default_nettype wire

// >>> verilog/channel_router_i2c_dispatch.sv
`timescale 1ns/100ps
`default_nettype none
module channel_router_i2c_dispatch (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    // Configuration and fitted options
    input  wire logic [1:0] app_type_i,
    input  wire logic       tx_fitted_i,
    // Control bus pins
    input  wire logic       ctrl_bus_rx_primary_i,
    input  wire logic       ctrl_bus_rx_secondary_i,
    output logic            ctrl_bus_tx_out_o,
    // Receive levels handed to the command decoder
    output logic            rx_primary_o,
    output logic            rx_secondary_o,
    // Reply bit stream from the reply generator
    input  wire logic       reply_bit_i,
    input  wire logic       reply_active_i,
    // Router command request from the decoder
    input  wire logic       req_valid_i,
    input  wire logic       req_from_secondary_i,
    input  wire logic [2:0] req_router_i,
    input  wire logic [7:0] req_data1_i,
    input  wire logic [7:0] req_data2_i,
    output logic            req_ready_o,
    output logic            req_refused_o,
    // Legacy command from the decoder
    input  wire logic       leg_valid_i,
    input  wire logic       leg_from_secondary_i,
    input  wire logic       leg_level_change_i,
    input  wire logic [3:0] leg_bits_i,
    output logic            leg_refused_o,
    // Transfer status
    output logic            busy_o,
    output logic            done_o,
    output logic            nack_o,
    // Serial lines, open drain except lines 2 and 3 as matrix outputs, enables active low
    output logic [3:0]      scl_o,
    output logic [3:0]      scl_oe_n_o,
    output logic [3:0]      sda_o,
    output logic [3:0]      sda_oe_n_o,
    input  wire logic [3:0] sda_i
);

    router_dispatch_pkg::eng_state_t state;
    router_dispatch_pkg::eng_state_t next_state;

    logic [3:0] sda_meta;
    logic [3:0] sda_sync;
    logic [1:0] rx_meta;
    logic [1:0] rx_sync;
    logic [7:0] qcnt;
    logic [1:0] quarter;
    logic       qtick;
    logic [2:0] bit_idx;
    logic [1:0] byte_idx;
    logic [7:0] shifter;
    logic [7:0] data1;
    logic [7:0] data2;
    logic [1:0] line_sel;
    logic       scl_lvl;
    logic       sda_lvl;
    logic       legacy_seen;
    logic       leg_pending;
    logic [3:0] leg_data;
    logic [3:0] matrix;
    logic       matrix_mode;
    logic       req_ok;
    logic       leg_ok;
    logic       start_req;
    logic       start_leg;

    // Slave address of a router: even numbers one, odd the other
    function automatic logic [7:0] router_addr(input logic [2:0] num);
        router_addr = num[0] ? router_dispatch_pkg::ADDR_ODD : router_dispatch_pkg::ADDR_EVEN;
    endfunction : router_addr

    // Is this router reachable as an ordinary router in the current application
    function automatic logic router_allowed(input logic [2:0] num, input logic [1:0] app);
        case (app)
            router_dispatch_pkg::APP_ROUTER_ONLY: router_allowed = 1'b1;
            router_dispatch_pkg::APP_LEGACY_STD:  router_allowed = num < router_dispatch_pkg::FIRST_STD_MATRIX;
            router_dispatch_pkg::APP_LEGACY_WIDE: router_allowed = num != router_dispatch_pkg::LEGACY_ROUTER;
            default:                              router_allowed = 1'b0;
        endcase
    endfunction : router_allowed

    // Pins cross into this clock through two flops; only stage two is read
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sda_meta <= 4'hF;
            sda_sync <= 4'hF;
            rx_meta  <= 2'h3;
            rx_sync  <= 2'h3;
        end else begin
            sda_meta <= sda_i;
            sda_sync <= sda_meta;
            rx_meta  <= {ctrl_bus_rx_secondary_i, ctrl_bus_rx_primary_i};
            rx_sync  <= rx_meta;
        end
    end

    // Primary is the default source; secondary only adds to it
    assign rx_primary_o   = rx_sync[0];
    assign rx_secondary_o = rx_sync[1];

    // Replies only leave when the transmit transistor is fitted; line idles high
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_bus_tx_out_o <= 1'b1;
        end else begin
            ctrl_bus_tx_out_o <= (tx_fitted_i && reply_active_i) ? reply_bit_i : 1'b1;
        end
    end

    // Acceptance of requests; router numbers map to filters in rising order
    assign req_ok      = router_allowed(req_router_i, app_type_i);
    assign matrix_mode = app_type_i == router_dispatch_pkg::APP_LEGACY_STD;
    // Legacy from the secondary only for a level change after a primary legacy command
    assign leg_ok      = (app_type_i != router_dispatch_pkg::APP_ROUTER_ONLY)
                         && (!leg_from_secondary_i || (leg_level_change_i && legacy_seen));
    assign start_leg   = state == router_dispatch_pkg::ST_IDLE && leg_pending;
    assign start_req   = state == router_dispatch_pkg::ST_IDLE && !leg_pending && req_valid_i && req_ok;
    assign req_ready_o = state == router_dispatch_pkg::ST_IDLE && !leg_pending;

    // One-cycle refusals; secondary router commands are accepted like primary ones
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_refused_o <= 1'b0;
            leg_refused_o <= 1'b0;
        end else begin
            req_refused_o <= req_valid_i && req_ready_o && !req_ok;
            leg_refused_o <= leg_valid_i && !leg_ok;
        end
    end

    // Legacy memory: a primary legacy command arms the secondary level change
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            legacy_seen <= 1'b0;
            matrix      <= 4'h0;
            leg_pending <= 1'b0;
            leg_data    <= 4'h0;
        end else begin
            if (leg_valid_i && leg_ok && !leg_from_secondary_i) begin
                legacy_seen <= 1'b1;
            end
            if (leg_valid_i && leg_ok && matrix_mode) begin
                matrix <= leg_bits_i;
            end
            // New legacy event wins over the clear of the pending flag
            if (leg_valid_i && leg_ok && app_type_i == router_dispatch_pkg::APP_LEGACY_WIDE) begin
                leg_pending <= 1'b1;
                leg_data    <= leg_bits_i;
            end else if (start_leg) begin
                leg_pending <= 1'b0;
            end
        end
    end

    // Quarter-period timebase of the serial clock, stopped while idle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            qcnt    <= 8'h00;
            quarter <= 2'h0;
        end else if (state == router_dispatch_pkg::ST_IDLE) begin
            qcnt    <= 8'h00;
            quarter <= 2'h0;
        end else if (qtick) begin
            qcnt    <= 8'h00;
            quarter <= quarter + 2'h1;
        end else begin
            qcnt    <= qcnt + 8'h01;
        end
    end
    assign qtick = qcnt == router_dispatch_pkg::QUARTER_CYC - 8'h01;
    localparam logic [1:0] Q_END = router_dispatch_pkg::Q_LAST;

    // Engine sequencing: start, address, two data bytes with acks, stop; a refused ack goes straight to stop
    always_comb begin
        next_state = state;
        unique case (state)
            router_dispatch_pkg::ST_IDLE:  if (start_req || start_leg) next_state = router_dispatch_pkg::ST_START;
            router_dispatch_pkg::ST_START: if (qtick && quarter == Q_END) next_state = router_dispatch_pkg::ST_SEND;
            router_dispatch_pkg::ST_SEND:  if (qtick && quarter == Q_END && bit_idx == router_dispatch_pkg::LAST_BIT)
                                               next_state = router_dispatch_pkg::ST_ACK;
            router_dispatch_pkg::ST_ACK:   if (qtick && quarter == Q_END)
                                               next_state = (nack_o || byte_idx == router_dispatch_pkg::LAST_BYTE)
                                                            ? router_dispatch_pkg::ST_STOP : router_dispatch_pkg::ST_SEND;
            router_dispatch_pkg::ST_STOP:  if (qtick && quarter == Q_END) next_state = router_dispatch_pkg::ST_IDLE;
            default:                       next_state = router_dispatch_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= router_dispatch_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Frame data: address of the selected router first, then the two bytes
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shifter  <= 8'h00;
            data1    <= 8'h00;
            data2    <= 8'h00;
            line_sel <= 2'h0;
            bit_idx  <= 3'h0;
            byte_idx <= 2'h0;
        end else if (start_leg) begin
            shifter  <= router_addr(router_dispatch_pkg::LEGACY_ROUTER);
            data1    <= {4'h0, leg_data};
            data2    <= 8'h00;
            line_sel <= router_dispatch_pkg::LEGACY_ROUTER[2:1];
            bit_idx  <= 3'h0;
            byte_idx <= 2'h0;
        end else if (start_req) begin
            shifter  <= router_addr(req_router_i);
            data1    <= req_data1_i;
            data2    <= req_data2_i;
            line_sel <= req_router_i[2:1];
            bit_idx  <= 3'h0;
            byte_idx <= 2'h0;
        end else if (qtick && quarter == Q_END) begin
            if (state == router_dispatch_pkg::ST_SEND) begin
                shifter <= {shifter[6:0], 1'b0};
                bit_idx <= bit_idx + 3'h1;
            end else if (state == router_dispatch_pkg::ST_ACK) begin
                byte_idx <= byte_idx + 2'h1;
                shifter  <= (byte_idx == 2'h0) ? data1 : data2;
            end
        end
    end

    // Line levels per quarter; data only moves while the clock is low
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_lvl <= 1'b1;
            sda_lvl <= 1'b1;
        end else if (qtick) begin
            unique case (state)
                router_dispatch_pkg::ST_START: begin
                    sda_lvl <= quarter == 2'h0 ? 1'b0 : sda_lvl;
                    scl_lvl <= quarter == 2'h1 ? 1'b0 : scl_lvl;
                end
                router_dispatch_pkg::ST_SEND: begin
                    sda_lvl <= quarter == 2'h0 ? shifter[7] : sda_lvl;
                    scl_lvl <= quarter == 2'h1 || quarter == 2'h2; // High only after data has settled
                end
                router_dispatch_pkg::ST_ACK: begin
                    sda_lvl <= 1'b1; // Released so the router can pull low
                    scl_lvl <= quarter == 2'h1 || quarter == 2'h2;
                end
                router_dispatch_pkg::ST_STOP: begin
                    sda_lvl <= (quarter == 2'h0 || quarter == 2'h1) ? 1'b0 : 1'b1; // Rises a quarter after the clock
                    scl_lvl <= quarter != 2'h0 || scl_lvl;
                end
                default: begin
                    scl_lvl <= 1'b1;
                    sda_lvl <= 1'b1;
                end
            endcase
        end
    end

    // Acknowledge sampled at the end of quarter one, as the clock rises; busy and done for the decoder
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            nack_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            if (start_req || start_leg) begin
                nack_o <= 1'b0;
            end else if (state == router_dispatch_pkg::ST_ACK && qtick && quarter == 2'h1) begin
                nack_o <= nack_o | sda_sync[line_sel];
            end
            done_o <= state == router_dispatch_pkg::ST_STOP && qtick && quarter == Q_END;
        end
    end
    assign busy_o = state != router_dispatch_pkg::ST_IDLE;

    // Pin muxing: only the selected line toggles; lines 2 and 3 become matrix outputs in the standard legacy application
    always_comb begin
        for (int i = 0; i < router_dispatch_pkg::NUM_LINES; i++) begin
            scl_o[i]      = 1'b0;
            sda_o[i]      = 1'b0;
            scl_oe_n_o[i] = !(busy_o && line_sel == 2'(i) && !scl_lvl);
            sda_oe_n_o[i] = !(busy_o && line_sel == 2'(i) && !sda_lvl);
        end
        if (matrix_mode) begin
            scl_o[2]      = matrix[0];
            sda_o[2]      = matrix[1];
            scl_o[3]      = matrix[2];
            sda_o[3]      = matrix[3];
            scl_oe_n_o[3:2] = 2'h0;
            sda_oe_n_o[3:2] = 2'h0;
        end
    end

endmodule : channel_router_i2c_dispatch
`default_nettype wire

// >>> verilog/router_dispatch_pkg.sv
package router_dispatch_pkg;

    // Application types selected by the stored configuration
    localparam logic [1:0] APP_ROUTER_ONLY  = 2'h0;
    localparam logic [1:0] APP_LEGACY_STD   = 2'h1;
    localparam logic [1:0] APP_LEGACY_WIDE  = 2'h2;

    // Router numbering and slave addresses (write direction, bit 0 low)
    localparam int         NUM_ROUTERS      = 8;
    localparam int         NUM_LINES        = 4;
    localparam logic [2:0] LEGACY_ROUTER    = 3'h7;
    localparam logic [2:0] FIRST_STD_MATRIX = 3'h4;
    localparam logic [7:0] ADDR_EVEN        = 8'hC8;
    localparam logic [7:0] ADDR_ODD         = 8'hCA;

    // Serial clock timing at a 20 MHz system clock
    localparam int         CLK_PERIOD_NS    = 50;
    localparam int         QUARTER_NS       = 2500;
    localparam int         QUARTER_CYC_INT  = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] QUARTER_CYC      = 8'(QUARTER_CYC_INT);

    // Frame layout: address byte, then two data bytes
    localparam logic [1:0] LAST_BYTE        = 2'h2;
    localparam logic [2:0] LAST_BIT         = 3'h7;
    localparam logic [1:0] Q_LAST           = 2'h3;

    // Bit engine states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_START = 5'h02,
        ST_SEND  = 5'h04,
        ST_ACK   = 5'h08,
        ST_STOP  = 5'h10
    } eng_state_t;

endpackage : router_dispatch_pkg
